// file: common/cpu_seq_pkg.sv
package cpu_seq_pkg;

    // Stack window: ten fixed upper address bits and six live pointer bits.
    localparam logic [9:0] STACK_HI = 10'h003;
    localparam logic [5:0] SP_RESET = 6'h3F;

    // Vector table, high byte at the even address and low byte one above.
    localparam logic [15:0] VEC_RESET = 16'h1FFE;
    localparam logic [15:0] VEC_SWI = 16'h1FFC;
    localparam logic [15:0] VEC_EXT = 16'h1FFA;
    localparam logic [15:0] VEC_USB = 16'h1FF8;
    localparam logic [15:0] VEC_TMR = 16'h1FF6;
    localparam logic [15:0] VEC_MFT = 16'h1FF4;

    // Flag bit positions and the constant upper bits.
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_N = 2;
    localparam int FLG_I = 3;
    localparam int FLG_H = 4;
    localparam logic [2:0] FLAGS_ONES = 3'h7;

    // Last byte index of each stacking sequence.
    localparam logic [2:0] CALL_LAST = 3'h1;
    localparam logic [2:0] INT_LAST = 3'h4;

    // Register byte offsets.
    localparam logic [31:0] OFF_ACC = 32'h0000_0000;
    localparam logic [31:0] OFF_IDX = 32'h0000_0004;
    localparam logic [31:0] OFF_SP = 32'h0000_0008;
    localparam logic [31:0] OFF_PC = 32'h0000_000C;
    localparam logic [31:0] OFF_FLAGS = 32'h0000_0010;
    localparam logic [31:0] OFF_ENABLE = 32'h0000_0014;
    localparam logic [31:0] OFF_STATUS = 32'h0000_0018;

    // Local enable bit positions and their reset value.
    localparam int EN_EXT = 0;
    localparam int EN_EP0 = 1;
    localparam int EN_EP1 = 2;
    localparam int EN_CAP = 3;
    localparam int EN_CMP = 4;
    localparam int EN_TOV = 5;
    localparam int EN_AUXOV = 6;
    localparam int EN_TICK = 7;
    localparam logic [7:0] ENABLE_RESET = 8'h01;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [2:0] {
        ALU_ADD = 3'h0,
        ALU_ADC = 3'h1,
        ALU_SUB = 3'h2,
        ALU_LOGIC = 3'h3,
        ALU_LOAD = 3'h4,
        ALU_INCDEC = 3'h5,
        ALU_SHIFT = 3'h6,
        ALU_BTEST = 3'h7
    } alu_kind_t;

    typedef enum logic [4:0] {
        ST_RUN = 5'h01,
        ST_PUSH = 5'h02,
        ST_VEC_HI = 5'h04,
        ST_VEC_LO = 5'h08,
        ST_PULL = 5'h10
    } seq_state_t;

endpackage : cpu_seq_pkg

// file: rtl/flag_calc.sv
`timescale 1ns/1ps
module flag_calc (
    input wire cpu_seq_pkg::alu_kind_t kind,
    input wire logic [7:0] acc,
    input wire logic [7:0] operand,
    input wire logic carry_in,
    input wire logic shift_c,
    output logic [7:0] result,
    output logic [4:0] upd,
    output logic [4:0] val
);
    logic [8:0] sum9;
    logic [8:0] diff9;
    logic adc_c;

    // Adder and subtractor share the accumulator as first operand.
    assign adc_c = (kind == cpu_seq_pkg::ALU_ADC) ? carry_in : 1'b0;
    assign sum9 = {1'b0, acc} + {1'b0, operand} + {8'h00, adc_c};
    assign diff9 = {1'b0, acc} - {1'b0, operand};

    // Result and the flags each kind of operation touches.
    always_comb begin
        result = operand;
        upd = 5'h00;
        val = 5'h00;
        case (kind)
            cpu_seq_pkg::ALU_ADD, cpu_seq_pkg::ALU_ADC: begin
                result = sum9[7:0];
                upd = 5'h17;
                val[cpu_seq_pkg::FLG_H] = acc[4] ^ operand[4] ^ sum9[4];
                val[cpu_seq_pkg::FLG_C] = sum9[8];
            end
            cpu_seq_pkg::ALU_SUB: begin
                result = diff9[7:0];
                upd = 5'h07;
                val[cpu_seq_pkg::FLG_C] = diff9[8];
            end
            cpu_seq_pkg::ALU_SHIFT: begin
                upd = 5'h07;
                val[cpu_seq_pkg::FLG_C] = shift_c;
            end
            cpu_seq_pkg::ALU_BTEST: begin
                result = acc;
                upd = 5'h01;
                val[cpu_seq_pkg::FLG_C] = shift_c;
            end
            default: begin
                // Logic, load, increment and decrement leave carry alone.
                upd = 5'h06;
            end
        endcase
        if (upd[cpu_seq_pkg::FLG_N]) begin
            val[cpu_seq_pkg::FLG_N] = result[7];
            val[cpu_seq_pkg::FLG_Z] = (result == 8'h00);
        end
    end

endmodule : flag_calc

// file: rtl/cpu_state_seq.sv
// What this block does
// - Stack pointer has six live bits; below the bottom it wraps to the top.
// - Reset and the stack reset instruction load the pointer to the top.
// - Pointer names the next free byte: decrement after push, increment before pull.
// - A call pushes two bytes, interrupt entry pushes five.
// - Accumulator and index keep their contents across reset.
// - Indexed address is index, or index plus an 8- or 16-bit offset.
// - Program counter steps on each fetch; jumps and interrupts load it.
// - Five flag bits, upper three read one; reset touches only the mask.
// - Half carry is the carry from bit 3 into bit 4 on adds.
// - Negative flag copies bit 7 of each result and each load; bit tests leave it unchanged.
// - Zero flag is set exactly when the result is zero.
// - Carry from arithmetic, shifts, rotates and bit tests; not from inc/dec.
// - Mask is set after stacking and before the vector fetch.
// - Requests arriving while masked stay pending until the mask clears.
// - Return pulls every stacked register, mask included, and resumes.
// - Reset sets the mask; mask-clear, wait or a return that pulls a clear mask clear it.
// - Hardware interrupts are taken only at the end of an instruction.
// - Taken only with mask clear and local enable set; resume has no enable.
// - Priority after stacking: external, then USB, then timer, then MULTI_FUNCTION_TIMER.
// - Each source fetches its two-byte handler address from its own vector.
// - The software trap enters unconditionally, regardless of the mask.
// - Reset sets the mask and loads the counter from the reset vector.
// - Fetching the external vector clears the external request flag.
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module cpu_state_seq (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic int_reset,
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic seq_ready,
    input wire logic fetch_stb,
    input wire logic jump_valid,
    input wire logic [15:0] jump_target,
    input wire logic call_valid,
    input wire logic instr_done,
    input wire logic alu_valid,
    input wire cpu_seq_pkg::alu_kind_t alu_kind,
    input wire logic [7:0] alu_operand,
    input wire logic alu_shift_c,
    input wire logic alu_to_idx,
    input wire logic ea_req,
    input wire logic [1:0] ea_mode,
    input wire logic [15:0] ea_offset,
    output logic [15:0] ea_addr,
    input wire logic stack_reset_instruction,
    input wire logic mask_clear_instruction,
    input wire logic wait_instruction,
    input wire logic software_trap,
    input wire logic return_from_exception,
    input wire logic ext_request_flag,
    input wire logic ep0_tx_done_flag,
    input wire logic ep1_tx_done_flag,
    input wire logic bus_resume_flag,
    input wire logic capture_event_flag,
    input wire logic compare_event_flag,
    input wire logic timer_overflow_flag,
    input wire logic aux_overflow_flag,
    input wire logic periodic_tick_flag,
    output logic ext_request_clear,
    output logic mem_req,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_ack,
    output logic [7:0] acc_q,
    output logic [7:0] idx_q,
    output logic [15:0] sp_q,
    output logic [15:0] pc_q,
    output logic [7:0] flags_q
);
    // Register select codes; 7 marks an unmapped address.
    function automatic logic [2:0] reg_sel(input logic [31:0] a);
        logic [2:0] s;
        s = 3'h7;
        case (a)
            cpu_seq_pkg::OFF_ACC: s = 3'h0;
            cpu_seq_pkg::OFF_IDX: s = 3'h1;
            cpu_seq_pkg::OFF_SP: s = 3'h2;
            cpu_seq_pkg::OFF_PC: s = 3'h3;
            cpu_seq_pkg::OFF_FLAGS: s = 3'h4;
            cpu_seq_pkg::OFF_ENABLE: s = 3'h5;
            cpu_seq_pkg::OFF_STATUS: s = 3'h6;
            default: s = 3'h7;
        endcase
        return s;
    endfunction : reg_sel

    logic rst;
    logic [7:0] acc_r;
    logic [7:0] idx_r;
    logic [5:0] sp_r;
    logic [15:0] pc_r;
    logic [4:0] flg_r;
    logic [7:0] en_r;
    cpu_seq_pkg::seq_state_t state_r;
    logic [2:0] cnt_r;
    logic is_int_r;
    logic [15:0] vec_r;
    logic [15:0] tgt_r;
    logic [7:0] vhi_r;
    logic ext_clr_r;
    logic [15:0] ea_r;
    logic aw_got_r;
    logic w_got_r;
    logic [31:0] awaddr_r;
    logic [7:0] wdata_r;
    logic wlane_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    assign rst = ~aresetn | int_reset;

    // Sources gated by their local enables; resume has none.
    logic p_ext;
    logic p_usb;
    logic p_tmr;
    logic p_mft;
    logic any_pend;
    logic hw_take;
    logic [15:0] vec_hw;
    assign p_ext = ext_request_flag & en_r[cpu_seq_pkg::EN_EXT];
    assign p_usb = (ep0_tx_done_flag & en_r[cpu_seq_pkg::EN_EP0])
                 | (ep1_tx_done_flag & en_r[cpu_seq_pkg::EN_EP1])
                 | bus_resume_flag;
    assign p_tmr = (capture_event_flag & en_r[cpu_seq_pkg::EN_CAP])
                 | (compare_event_flag & en_r[cpu_seq_pkg::EN_CMP])
                 | (timer_overflow_flag & en_r[cpu_seq_pkg::EN_TOV]);
    assign p_mft = (aux_overflow_flag & en_r[cpu_seq_pkg::EN_AUXOV])
                 | (periodic_tick_flag & en_r[cpu_seq_pkg::EN_TICK]);
    assign any_pend = p_ext | p_usb | p_tmr | p_mft;
    // Level requests simply wait while the mask is set.
    assign hw_take = ~flg_r[cpu_seq_pkg::FLG_I] & any_pend;
    assign vec_hw = p_ext ? cpu_seq_pkg::VEC_EXT :
                    p_usb ? cpu_seq_pkg::VEC_USB :
                    p_tmr ? cpu_seq_pkg::VEC_TMR : cpu_seq_pkg::VEC_MFT;

    // Sequencer decode of the current step.
    logic run;
    logic in_push;
    logic in_pull;
    logic step;
    logic push_last;
    logic [2:0] push_end;
    logic take_int;
    logic [5:0] sp_up;
    assign run = (state_r == cpu_seq_pkg::ST_RUN);
    assign in_push = (state_r == cpu_seq_pkg::ST_PUSH);
    assign in_pull = (state_r == cpu_seq_pkg::ST_PULL);
    assign step = ~run & mem_ack;
    assign push_end = is_int_r ? cpu_seq_pkg::INT_LAST : cpu_seq_pkg::CALL_LAST;
    assign push_last = (cnt_r == push_end);
    assign take_int = run & (software_trap | (instr_done & hw_take));
    assign sp_up = sp_r + 6'h01;

    // Byte to push: PCL, PCH, X, A, flags.
    logic [7:0] push_byte;
    always_comb begin
        case (cnt_r)
            3'h0: push_byte = pc_r[7:0];
            3'h1: push_byte = pc_r[15:8];
            3'h2: push_byte = idx_r;
            3'h3: push_byte = acc_r;
            default: push_byte = {cpu_seq_pkg::FLAGS_ONES, flg_r};
        endcase
    end

    // Memory port: stack bytes in the fixed window, vectors by address.
    assign mem_req = ~run;
    assign mem_we = in_push;
    assign mem_wdata = push_byte;
    assign mem_addr = in_push ? {cpu_seq_pkg::STACK_HI, sp_r} :
                      in_pull ? {cpu_seq_pkg::STACK_HI, sp_up} :
                      (state_r == cpu_seq_pkg::ST_VEC_LO) ? vec_r + 16'h0001 : vec_r;

    // Arithmetic and flag evaluation.
    logic [7:0] alu_res;
    logic [4:0] f_upd;
    logic [4:0] f_val;
    logic alu_wr;
    flag_calc u_flags (
        .kind(alu_kind),
        .acc(acc_r),
        .operand(alu_operand),
        .carry_in(flg_r[cpu_seq_pkg::FLG_C]),
        .shift_c(alu_shift_c),
        .result(alu_res),
        .upd(f_upd),
        .val(f_val)
    );
    assign alu_wr = run & alu_valid & (alu_kind != cpu_seq_pkg::ALU_BTEST);

    // Bus write strobes for the writable registers.
    logic wr_go;
    logic [2:0] wsel;
    logic bus_wr;
    assign wr_go = aw_got_r & w_got_r & ~bvalid_r;
    assign wsel = reg_sel(awaddr_r);
    assign bus_wr = wr_go & wlane_r;

    // Accumulator and index have no reset; pulls, ALU, then bus.
    always_ff @(posedge aclk) begin
        if (in_pull & step & (cnt_r == 3'h1)) begin
            acc_r <= mem_rdata;
        end else if (alu_wr & ~alu_to_idx) begin
            acc_r <= alu_res;
        end else if (bus_wr & (wsel == 3'h0)) begin
            acc_r <= wdata_r;
        end
        if (in_pull & step & (cnt_r == 3'h2)) begin
            idx_r <= mem_rdata;
        end else if (alu_wr & alu_to_idx) begin
            idx_r <= alu_res;
        end else if (bus_wr & (wsel == 3'h1)) begin
            idx_r <= wdata_r;
        end
    end

    // Condition flags: only the mask has a reset value.
    always_ff @(posedge aclk) begin
        for (int k = 0; k < 5; k++) begin
            if (k != cpu_seq_pkg::FLG_I && run && alu_valid && f_upd[k]) begin
                flg_r[k] <= f_val[k];
            end
        end
        if (rst) begin
            flg_r[cpu_seq_pkg::FLG_I] <= 1'b1;
        end else if (in_push & step & push_last & is_int_r) begin
            flg_r[cpu_seq_pkg::FLG_I] <= 1'b1;
        end else if (run & (mask_clear_instruction | wait_instruction)) begin
            flg_r[cpu_seq_pkg::FLG_I] <= 1'b0;
        end
        if (~rst & in_pull & step & (cnt_r == 3'h0)) begin
            flg_r <= mem_rdata[4:0];
        end
    end

    // Stack pointer: six bits wrap inside the window on their own.
    always_ff @(posedge aclk) begin
        if (rst) begin
            sp_r <= cpu_seq_pkg::SP_RESET;
        end else if (run & stack_reset_instruction) begin
            sp_r <= cpu_seq_pkg::SP_RESET;
        end else if (in_push & step) begin
            sp_r <= sp_r - 6'h01;
        end else if (in_pull & step) begin
            sp_r <= sp_up;
        end
    end

    // Program counter: steps on fetches, loaded by jumps and vectors.
    always_ff @(posedge aclk) begin
        if (rst) begin
            pc_r <= 16'h0000;
        end else if (state_r == cpu_seq_pkg::ST_VEC_LO && mem_ack) begin
            pc_r <= {vhi_r, mem_rdata};
        end else if (in_push & step & push_last & ~is_int_r) begin
            pc_r <= tgt_r;
        end else if (in_pull & step & (cnt_r == 3'h3)) begin
            pc_r[15:8] <= mem_rdata;
        end else if (in_pull & step & (cnt_r == cpu_seq_pkg::INT_LAST)) begin
            pc_r[7:0] <= mem_rdata;
        end else if (run & jump_valid) begin
            pc_r <= jump_target;
        end else if (run & fetch_stb) begin
            pc_r <= pc_r + 16'h0001;
        end
    end

    // Sequencer: stacking, vector fetch and return.
    always_ff @(posedge aclk) begin
        if (rst) begin
            state_r <= cpu_seq_pkg::ST_VEC_HI;
            vec_r <= cpu_seq_pkg::VEC_RESET;
            cnt_r <= 3'h0;
            is_int_r <= 1'b0;
            tgt_r <= 16'h0000;
            vhi_r <= 8'h00;
        end else begin
            case (state_r)
                cpu_seq_pkg::ST_RUN: begin
                    cnt_r <= 3'h0;
                    if (take_int) begin
                        state_r <= cpu_seq_pkg::ST_PUSH;
                        is_int_r <= 1'b1;
                        vec_r <= software_trap ? cpu_seq_pkg::VEC_SWI : vec_hw;
                    end else if (call_valid) begin
                        state_r <= cpu_seq_pkg::ST_PUSH;
                        is_int_r <= 1'b0;
                        tgt_r <= jump_target;
                    end else if (return_from_exception) begin
                        state_r <= cpu_seq_pkg::ST_PULL;
                    end
                end
                cpu_seq_pkg::ST_PUSH: begin
                    if (mem_ack) begin
                        cnt_r <= cnt_r + 3'h1;
                        if (push_last) begin
                            state_r <= is_int_r ? cpu_seq_pkg::ST_VEC_HI
                                                : cpu_seq_pkg::ST_RUN;
                            if (is_int_r & (vec_r != cpu_seq_pkg::VEC_SWI) & any_pend) begin
                                vec_r <= vec_hw;
                            end
                        end
                    end
                end
                cpu_seq_pkg::ST_VEC_HI: begin
                    if (mem_ack) begin
                        vhi_r <= mem_rdata;
                        state_r <= cpu_seq_pkg::ST_VEC_LO;
                    end
                end
                cpu_seq_pkg::ST_VEC_LO: begin
                    if (mem_ack) begin
                        state_r <= cpu_seq_pkg::ST_RUN;
                    end
                end
                cpu_seq_pkg::ST_PULL: begin
                    if (mem_ack) begin
                        cnt_r <= cnt_r + 3'h1;
                        if (cnt_r == cpu_seq_pkg::INT_LAST) begin
                            state_r <= cpu_seq_pkg::ST_RUN;
                        end
                    end
                end
                default: state_r <= cpu_seq_pkg::ST_RUN;
            endcase
        end
    end

    // One-cycle clear to the external request latch at its vector fetch.
    always_ff @(posedge aclk) begin
        if (rst) begin
            ext_clr_r <= 1'b0;
        end else begin
            ext_clr_r <= (state_r == cpu_seq_pkg::ST_VEC_HI) & mem_ack
                       & (vec_r == cpu_seq_pkg::VEC_EXT);
        end
    end

    // Indexed operand address, registered on request.
    logic [15:0] ea_nxt;
    assign ea_nxt = (ea_mode == 2'h0) ? {8'h00, idx_r} :
                    (ea_mode == 2'h1) ? {8'h00, idx_r} + {8'h00, ea_offset[7:0]} :
                    {8'h00, idx_r} + ea_offset;
    always_ff @(posedge aclk) begin
        if (rst) begin
            ea_r <= 16'h0000;
        end else if (ea_req) begin
            ea_r <= ea_nxt;
        end
    end

    // Local enable register, written over the bus.
    always_ff @(posedge aclk) begin
        if (rst) begin
            en_r <= cpu_seq_pkg::ENABLE_RESET;
        end else if (bus_wr & (wsel == 3'h5)) begin
            en_r <= wdata_r;
        end
    end

    // Write channels: address and data taken in any order, then answered.
    assign awready = ~aw_got_r & ~bvalid_r;
    assign wready = ~w_got_r & ~bvalid_r;
    always_ff @(posedge aclk) begin
        if (~aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 32'h0000_0000;
            wdata_r <= 8'h00;
            wlane_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= cpu_seq_pkg::RESP_OKAY;
        end else begin
            if (awvalid & awready) begin
                aw_got_r <= 1'b1;
                awaddr_r <= awaddr;
            end
            if (wvalid & wready) begin
                w_got_r <= 1'b1;
                wdata_r <= wdata[7:0];
                wlane_r <= wstrb[0];
            end
            if (wr_go) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= (wsel == 3'h7) ? cpu_seq_pkg::RESP_DECERR
                                          : cpu_seq_pkg::RESP_OKAY;
            end else if (bvalid_r & bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Read data selection; state bits show the sequencer and pending sources.
    logic [2:0] rsel;
    logic [31:0] rd_val;
    assign rsel = reg_sel(araddr);
    always_comb begin
        case (rsel)
            3'h0: rd_val = {24'h00_0000, acc_r};
            3'h1: rd_val = {24'h00_0000, idx_r};
            3'h2: rd_val = {16'h0000, cpu_seq_pkg::STACK_HI, sp_r};
            3'h3: rd_val = {16'h0000, pc_r};
            3'h4: rd_val = {24'h00_0000, cpu_seq_pkg::FLAGS_ONES, flg_r};
            3'h5: rd_val = {24'h00_0000, en_r};
            3'h6: rd_val = {23'h00_0000, state_r, p_mft, p_tmr, p_usb, p_ext};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // Read channel: one read at a time, answered on the same edge that takes it.
    assign arready = ~rvalid_r;
    always_ff @(posedge aclk) begin
        if (~aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= cpu_seq_pkg::RESP_OKAY;
        end else if (arvalid & arready) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_val;
            rresp_r <= (rsel == 3'h7) ? cpu_seq_pkg::RESP_DECERR : cpu_seq_pkg::RESP_OKAY;
        end else if (rvalid_r & rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Output view of the programmer state.
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign seq_ready = run;
    assign ea_addr = ea_r;
    assign ext_request_clear = ext_clr_r;
    assign acc_q = acc_r;
    assign idx_q = idx_r;
    assign sp_q = {cpu_seq_pkg::STACK_HI, sp_r};
    assign pc_q = pc_r;
    assign flags_q = {cpu_seq_pkg::FLAGS_ONES, flg_r};

endmodule : cpu_state_seq

// file: dv/cpu_state_seq_sva.sv
`timescale 1ns/1ps
module cpu_state_seq_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic mem_ack,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] sp_q,
    input wire logic [7:0] flags_q,
    input wire logic ext_request_clear
);
    // All checks run on the core clock and sleep while reset is low.
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_sp_hi; sp_q[15:6] == 10'h003; endproperty
    a_sp_hi: assert property (p_sp_hi) else $error("stack window");
    property p_ones; flags_q[7:5] == 3'h7; endproperty
    a_ones: assert property (p_ones) else $error("flag ones");
    property p_push; mem_we && mem_ack |=> sp_q[5:0] == $past(sp_q[5:0]) - 6'h01; endproperty
    a_push: assert property (p_push) else $error("push step");
    property p_push_addr; mem_we |-> mem_addr == sp_q; endproperty
    a_push_addr: assert property (p_push_addr) else $error("push address");
    property p_pull; mem_req && !mem_we && mem_addr[15:8] == 8'h00 |-> mem_addr[5:0] == sp_q[5:0] + 6'h01; endproperty
    a_pull: assert property (p_pull) else $error("pull address");
    property p_reset; $rose(aresetn) |-> mem_addr == 16'h1FFE && flags_q[3]; endproperty
    a_reset: assert property (p_reset) else $error("reset vector");
    property p_mask; mem_req && $fell(mem_we) |-> flags_q[3] && mem_addr[15:4] == 12'h1FF; endproperty
    a_mask: assert property (p_mask) else $error("mask order");
    property p_ext; ext_request_clear |-> $past(mem_addr) == 16'h1FFA; endproperty
    a_ext: assert property (p_ext) else $error("ext clear");
endmodule : cpu_state_seq_sva
bind cpu_state_seq cpu_state_seq_sva i_sva (.*);

// file: dv/prog_mem.sv
`timescale 1ns/1ps
module prog_mem (
    input wire logic aclk,
    input wire logic slow,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata,
    output logic mem_ack
);
    logic [7:0] m [0:65535];
    logic tick = 0;
    // Vector bytes hold a fixed pattern; in slow mode every other cycle stalls.
    initial for (int i = 16'h1FF4; i < 16'h2000; i++) m[i] = i[7:0] ^ 8'hA5;
    assign mem_ack = !slow || tick;
    assign mem_rdata = (mem_req && !mem_we) ? m[mem_addr] : ~m[mem_addr];
    // Pushes land on acknowledged cycles.
    always @(posedge aclk) begin
        tick <= !tick;
        if (mem_req && mem_we && mem_ack) m[mem_addr] <= mem_wdata;
    end
endmodule : prog_mem

// file: dv/tb.sv
`timescale 1ns/1ps
module tb;
    logic aclk = 0, aresetn = 0, slow = 0, int_reset = 0, fetch_stb = 0, jump_valid = 0;
    logic call_valid = 0, alu_shift_c = 0, alu_to_idx = 0, wait_instruction = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, ext_request_flag = 0;
    logic ep0_tx_done_flag = 0, ep1_tx_done_flag = 0, bus_resume_flag = 0;
    logic capture_event_flag = 0, compare_event_flag = 0, timer_overflow_flag = 0;
    logic aux_overflow_flag = 0, periodic_tick_flag = 0;
    logic instr_done, mask_clear_instruction, return_from_exception, software_trap;
    logic stack_reset_instruction, alu_valid, ea_req, awready, wready, bvalid, arready;
    logic rvalid, seq_ready, ext_request_clear, mem_req, mem_we, mem_ack;
    logic [1:0] bresp, rresp, ea_mode = 2'h1;
    logic [3:0] wstrb = 4'hF;
    logic [6:0] cmd = 7'h00;
    logic [7:0] alu_operand = 8'h00, mem_wdata, mem_rdata, acc_q, idx_q, flags_q;
    logic [15:0] jump_target = 16'h0000, ea_offset = 16'h0000, ea_addr, mem_addr, sp_q, pc_q;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    cpu_seq_pkg::alu_kind_t alu_kind = cpu_seq_pkg::ALU_ADD;
    int failures = 0, checks_done = 0, cyc = 0;
    assign {ea_req, alu_valid, stack_reset_instruction, software_trap, return_from_exception,
        mask_clear_instruction, instr_done} = cmd;
    cpu_state_seq i_dut (.*);
    prog_mem i_mem (.*);
    always #25 aclk = ~aclk;
    // A hang counts as a mismatch and ends the run.
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [35:0] g, e);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    // Write: both channels offered together, each released once taken.
    task automatic axw(input logic [31:0] a, d);
        logic ta, tw, done;
        @(posedge aclk) {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
        do begin
            @(negedge aclk) {ta, tw, done} = {awready & awvalid, wready & wvalid, bvalid};
            @(posedge aclk) {awvalid, wvalid, bready} <= {awvalid & !ta, wvalid & !tw, !done};
        end while (!done);
    endtask : axw
    task automatic axr(input logic [31:0] a, input logic [35:0] e);
        logic ta, done;
        logic [33:0] got;
        @(posedge aclk) {araddr, arvalid, rready} <= {a, 2'h3};
        do begin
            @(negedge aclk) {ta, done, got} = {arready & arvalid, rvalid, rresp, rdata};
            @(posedge aclk) {arvalid, rready} <= {arvalid & !ta, !done};
        end while (!done);
        chk(got, e);
    endtask : axr
    // One strobe at a rising edge, then wait until the sequencer idles again.
    task automatic op(input int b, input logic [7:0] d = 8'h00,
            input cpu_seq_pkg::alu_kind_t k = cpu_seq_pkg::ALU_ADD);
        @(posedge aclk) {cmd, alu_operand, ea_offset} <= {7'(1 << b), d, 8'h00, d};
        alu_kind <= k;
        @(posedge aclk) cmd <= 7'h00;
        do @(negedge aclk); while (seq_ready !== 1'b1);
    endtask : op
    // Reset, bus and flag tests, then masked, taken, returned and trapped interrupts.
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        op(7);
        chk({pc_q, sp_q, flags_q[7:5], flags_q[3]}, {16'h5B5A, 16'h00FF, 4'hF});
        $display("reset test end");
        axw(cpu_seq_pkg::OFF_ACC, 32'h8);
        axw(cpu_seq_pkg::OFF_IDX, 32'h30);
        axr(cpu_seq_pkg::OFF_IDX, 36'h30);
        axr(32'h100, {2'h3, 32'h0});
        op(5, 8'h08);
        chk({acc_q, flags_q}, 36'h10F8);
        op(5, 8'hF0);
        chk({acc_q, flags_q}, 36'h00EB);
        op(5, 8'h80, cpu_seq_pkg::ALU_LOAD);
        chk({acc_q, flags_q}, 36'h80ED);
        op(6, 8'hF0);
        chk(ea_addr, 36'h120);
        $display("bus and flag test end");
        @(posedge aclk) ext_request_flag <= 1;
        op(0);
        chk(pc_q, 36'h5B5A);
        @(posedge aclk) slow <= 1;
        op(1);
        op(0);
        chk({pc_q, sp_q, flags_q[3]}, {16'h5F5E, 16'h00FA, 1'b1});
        op(2);
        chk({pc_q, sp_q, flags_q[3]}, {16'h5B5A, 16'h00FF, 1'b0});
        op(3);
        chk({pc_q, sp_q}, {16'h5958, 16'h00FA});
        op(4);
        chk(sp_q, 36'h00FF);
        $display("interrupt test end");
        tally_and_finish();
    end
    // The external source drops its request when the core acknowledges it.
    always @(posedge aclk) if (ext_request_clear) ext_request_flag <= 0;
endmodule : tb
